// ### bus_timing_map.svh
`ifndef BUS_TIMING_MAP_SVH
`define BUS_TIMING_MAP_SVH

// ==========================================================
// Clock and conversions
`define CLK_MHZ 125
`define US2CYC(us) ((us) * `CLK_MHZ)
`define NS2CYC(ns) (((ns) * `CLK_MHZ) / 1000)

// ==========================================================
// State-machine clock periods
`define T_TICK_STD_NS 1000
`define T_TICK_OD_NS 50

// ==========================================================
// Line timing, microseconds (standard / overdrive / long line)
`define T_RSTL_STD_US 626
`define T_RSTL_OD_US 63
`define T_RSTH_STD_US 636
`define T_RSTH_OD_US 74
`define T_PDS_STD_US 31
`define T_PDS_LONG_US 38
`define T_PDS_OD_US 4
`define T_ABS_STD_US 75
`define T_ABS_OD_US 8
`define T_SLOT_STD_US 86
`define T_SLOT_OD_US 15
`define T_LOW1_STD_US 6
`define T_LOW1_LONG_US 9
`define T_LOW1_OD_US 1
`define T_LOW0_STD_US 78
`define T_LOW0_OD_US 10
`define T_RDV_STD_US 15
`define T_RDV_LONG_US 25
`define T_RDV_OD_US 2
`define T_PMM_US 15

// ==========================================================
// Strong pullup timing, microseconds
`define T_ON1_STD_US 8
`define T_ON1_OD_US 1
`define T_ON2_US 10
`define T_ON3_STD_US 64
`define T_ON3_OD_US 9
`define T_ON4_STD_US 8
`define T_ON4_OD_US 1
`define T_DLY1_US 1
`define T_DLY2_STD_US 499
`define T_DLY2_OD_US 39
`define T_DLY3_US 1
`define T_OFF1_US 2
`define T_OFF2_US 1
`define T_OFF_FIRST_US 4

`endif

// ### bus_timing_pkg.sv
package bus_timing_pkg;

  // ==========================================================
  // Modes and commands
  typedef enum logic [1:0] {
    SPEED_STD = 2'h0,
    SPEED_OD = 2'h1,
    SPEED_LONG = 2'h2
  } speed_e;

  typedef enum logic [1:0] {
    OP_RESET = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2
  } op_e;

  typedef struct packed {
    op_e op;
    logic bit_val;
    logic first_bit;
    logic last_bit;
  } cmd_s;

  typedef struct packed {
    op_e op;
    logic bit_val;
  } rsp_s;

  // ==========================================================
  // State machines
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_OFF = 5'h02,
    ST_LOW = 5'h04,
    ST_HIGH = 5'h08,
    ST_POST = 5'h10
  } seq_state_e;

  typedef enum logic [4:0] {
    SP_IDLE = 5'h01,
    SP_DELAY = 5'h02,
    SP_WAIT = 5'h04,
    SP_ON = 5'h08,
    SP_HOLD = 5'h10
  } spu_state_e;

  typedef enum logic [1:0] {
    PH_PRES1 = 2'h0,
    PH_PRES2 = 2'h1,
    PH_RECOV = 2'h2
  } spu_phase_e;

endpackage

// ### state_clock_tick.sv
`timescale 1ns/100ps
`include "bus_timing_map.svh"

module state_clock_tick (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fast_i,
  output logic tick_o
);
  localparam logic [6:0] STD_CYC = 7'(`NS2CYC(`T_TICK_STD_NS));
  localparam logic [6:0] OD_CYC = 7'(`NS2CYC(`T_TICK_OD_NS));

  logic [6:0] cnt_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 7'h00;
      tick_o <= 1'b0;
    end else if (cnt_reg >= (fast_i ? OD_CYC : STD_CYC) - 7'h01) begin
      cnt_reg <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
      tick_o <= 1'b0;
    end
  end
endmodule

// ### result_skid_buffer.sv
`timescale 1ns/100ps

module result_skid_buffer
  import bus_timing_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire rsp_s in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output rsp_s out_data_o
);
  logic skid_valid_reg;
  rsp_s skid_data_reg;
  logic in_fire;

  assign in_ready_o = !skid_valid_reg;
  assign in_fire = in_valid_i && !skid_valid_reg;

  // ==========================================================
  // Output stage, refilled from the skid entry first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (!out_valid_o || out_ready_i) begin
      if (skid_valid_reg) begin
        out_valid_o <= 1'b1;
        out_data_o <= skid_data_reg;
      end else begin
        out_valid_o <= in_fire;
        if (in_fire) begin
          out_data_o <= in_data_i;
        end
      end
    end
  end

  // ==========================================================
  // Second entry, filled while the receiver stalls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      skid_valid_reg <= 1'b0;
      skid_data_reg <= '0;
    end else if (!out_valid_o || out_ready_i) begin
      skid_valid_reg <= 1'b0;
    end else if (in_fire) begin
      skid_valid_reg <= 1'b1;
      skid_data_reg <= in_data_i;
    end
  end
endmodule

// ### single_wire_bus_master_timing.sv
`timescale 1ns/100ps
`include "bus_timing_map.svh"

module single_wire_bus_master_timing
  import bus_timing_pkg::*;
#(
  parameter logic [16:0] RSTL_STD_CYC = 17'(`US2CYC(`T_RSTL_STD_US)),
  parameter logic [16:0] RSTL_OD_CYC = 17'(`US2CYC(`T_RSTL_OD_US)),
  parameter logic [16:0] RSTH_STD_CYC = 17'(`US2CYC(`T_RSTH_STD_US)),
  parameter logic [16:0] RSTH_OD_CYC = 17'(`US2CYC(`T_RSTH_OD_US)),
  parameter logic [16:0] ABS_STD_CYC = 17'(`US2CYC(`T_ABS_STD_US)),
  parameter logic [16:0] PDS_LONG_CYC = 17'(`US2CYC(`T_PDS_LONG_US)),
  parameter logic [16:0] SLOT_STD_CYC = 17'(`US2CYC(`T_SLOT_STD_US)),
  parameter logic [16:0] LOW0_STD_CYC = 17'(`US2CYC(`T_LOW0_STD_US)),
  parameter logic [16:0] ON3_STD_CYC = 17'(`US2CYC(`T_ON3_STD_US)),
  parameter logic [16:0] DLY2_STD_CYC = 17'(`US2CYC(`T_DLY2_STD_US)),
  parameter logic [16:0] DLY2_OD_CYC = 17'(`US2CYC(`T_DLY2_OD_US))
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire cmd_s CMD_I,
  input wire speed_e SPEED_I,
  input wire logic PULSE_MASKING_MODE_I,
  input wire logic SPU_CONTINUOUS_I,
  input wire logic BUS_LINE_I,
  output logic BUS_LINE_O,
  output logic BUS_LINE_OE_O,
  output logic STRONG_PULLUP_ENABLE_N_O,
  output logic RSP_VALID_O,
  input wire logic RSP_READY_I,
  output rsp_s RSP_O
);
  // ==========================================================
  // Cycle counts
  localparam logic [16:0] PDS_STD = 17'(`US2CYC(`T_PDS_STD_US));
  localparam logic [16:0] PDS_OD = 17'(`US2CYC(`T_PDS_OD_US));
  localparam logic [16:0] ABS_OD = 17'(`US2CYC(`T_ABS_OD_US));
  localparam logic [16:0] SLOT_OD = 17'(`US2CYC(`T_SLOT_OD_US));
  localparam logic [16:0] LOW1_STD = 17'(`US2CYC(`T_LOW1_STD_US));
  localparam logic [16:0] LOW1_LONG = 17'(`US2CYC(`T_LOW1_LONG_US));
  localparam logic [16:0] LOW1_OD = 17'(`US2CYC(`T_LOW1_OD_US));
  localparam logic [16:0] LOW0_OD = 17'(`US2CYC(`T_LOW0_OD_US));
  localparam logic [16:0] RDV_STD = 17'(`US2CYC(`T_RDV_STD_US));
  localparam logic [16:0] RDV_LONG = 17'(`US2CYC(`T_RDV_LONG_US));
  localparam logic [16:0] RDV_OD = 17'(`US2CYC(`T_RDV_OD_US));
  localparam logic [16:0] PMM_CYC = 17'(`US2CYC(`T_PMM_US));
  localparam logic [16:0] ON1_STD = 17'(`US2CYC(`T_ON1_STD_US));
  localparam logic [16:0] ON1_OD = 17'(`US2CYC(`T_ON1_OD_US));
  localparam logic [16:0] ON2_CYC = 17'(`US2CYC(`T_ON2_US));
  localparam logic [16:0] ON3_OD = 17'(`US2CYC(`T_ON3_OD_US));
  localparam logic [16:0] ON4_STD = 17'(`US2CYC(`T_ON4_STD_US));
  localparam logic [16:0] ON4_OD = 17'(`US2CYC(`T_ON4_OD_US));
  localparam logic [16:0] DLY1_CYC = 17'(`US2CYC(`T_DLY1_US));
  localparam logic [16:0] DLY3_CYC = 17'(`US2CYC(`T_DLY3_US));
  localparam logic [16:0] OFF1_CYC = 17'(`US2CYC(`T_OFF1_US));
  localparam logic [16:0] OFF2_CYC = 17'(`US2CYC(`T_OFF2_US));
  localparam logic [16:0] OFF_FIRST = 17'(`US2CYC(`T_OFF_FIRST_US));

  seq_state_e st_reg;
  spu_state_e sp_reg;
  spu_phase_e ph_reg;
  cmd_s cmd_reg;
  speed_e speed_reg;
  logic pmm_reg;
  logic cont_reg;
  logic line_oe_reg;
  logic found_reg;
  logic spu_n_reg;
  logic [16:0] cnt_reg;
  logic [16:0] off_reg;
  logic [16:0] low_reg;
  logic [16:0] high_reg;
  logic [16:0] samp_reg;
  logic [16:0] win_reg;
  logic [16:0] sp_cnt_reg;
  logic [16:0] sp_dur_reg;
  logic [16:0] off_next;
  logic [16:0] low_next;
  logic [16:0] high_next;
  logic [16:0] samp_next;
  logic [16:0] win_next;
  logic [16:0] low1;
  logic [16:0] slot;
  logic [16:0] rdv;
  logic take;
  logic release_now;
  logic mask_now;
  logic od;
  logic lg;
  logic sp_od;
  logic tick;
  logic line_high_ok;
  logic buf_ready;
  rsp_s rsp_in;

  assign take = CMD_VALID_I && CMD_READY_O;
  assign od = (SPEED_I == SPEED_OD);
  assign lg = (SPEED_I == SPEED_LONG);
  assign sp_od = (speed_reg == SPEED_OD);
  assign release_now = (st_reg == ST_LOW) && (cnt_reg == low_reg - 17'h00001);
  assign BUS_LINE_O = 1'b0;
  assign BUS_LINE_OE_O = line_oe_reg;
  assign STRONG_PULLUP_ENABLE_N_O = spu_n_reg;

  // ==========================================================
  // Interval selection at command take
  always_comb begin
    low1 = od ? LOW1_OD : (lg ? LOW1_LONG : LOW1_STD);
    slot = od ? SLOT_OD : SLOT_STD_CYC;
    rdv = od ? RDV_OD : (lg ? RDV_LONG : RDV_STD);
    off_next = OFF2_CYC;
    low_next = low1;
    high_next = slot - low1;
    samp_next = rdv - low1;
    win_next = rdv - low1;
    if (CMD_I.op == OP_RESET) begin
      off_next = OFF1_CYC;
      low_next = od ? RSTL_OD_CYC : RSTL_STD_CYC;
      high_next = od ? RSTH_OD_CYC : RSTH_STD_CYC;
      samp_next = od ? PDS_OD : (lg ? PDS_LONG_CYC : PDS_STD);
      win_next = od ? ABS_OD : ABS_STD_CYC;
    end else begin
      if (CMD_I.first_bit) begin
        off_next = OFF_FIRST;
      end
      if (CMD_I.op == OP_WRITE && !CMD_I.bit_val) begin
        low_next = od ? LOW0_OD : LOW0_STD_CYC;
        high_next = slot - low_next;
      end
    end
  end

  // ==========================================================
  // Sequence controller
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 17'h00000;
      CMD_READY_O <= 1'b1;
      cmd_reg <= '0;
      speed_reg <= SPEED_STD;
      pmm_reg <= 1'b0;
      cont_reg <= 1'b0;
      off_reg <= 17'h00000;
      low_reg <= 17'h00000;
      high_reg <= 17'h00000;
      samp_reg <= 17'h00000;
      win_reg <= 17'h00000;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (take) begin
            st_reg <= ST_OFF;
            cnt_reg <= 17'h00000;
            CMD_READY_O <= 1'b0;
            cmd_reg <= CMD_I;
            speed_reg <= SPEED_I;
            pmm_reg <= PULSE_MASKING_MODE_I;
            cont_reg <= SPU_CONTINUOUS_I;
            off_reg <= off_next;
            low_reg <= low_next;
            high_reg <= high_next;
            samp_reg <= samp_next;
            win_reg <= win_next;
          end
        end
        ST_OFF: begin
          if (cnt_reg == off_reg - 17'h00001) begin
            st_reg <= ST_LOW;
            cnt_reg <= 17'h00000;
          end else begin
            cnt_reg <= cnt_reg + 17'h00001;
          end
        end
        ST_LOW: begin
          if (release_now) begin
            st_reg <= ST_HIGH;
            cnt_reg <= 17'h00000;
          end else begin
            cnt_reg <= cnt_reg + 17'h00001;
          end
        end
        ST_HIGH: begin
          if (cnt_reg == high_reg - 17'h00001) begin
            st_reg <= ST_POST;
            cnt_reg <= 17'h00000;
          end else begin
            cnt_reg <= cnt_reg + 17'h00001;
          end
        end
        ST_POST: begin
          if (buf_ready) begin
            st_reg <= ST_IDLE;
            CMD_READY_O <= 1'b1;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
          CMD_READY_O <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Line drive
  // masking after 15 us of a standard reset
  assign mask_now = pmm_reg && (speed_reg == SPEED_STD) && (cmd_reg.op == OP_RESET)
                    && (st_reg == ST_HIGH) && (cnt_reg >= PMM_CYC - 17'h00001)
                    && (cnt_reg != high_reg - 17'h00001);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      line_oe_reg <= 1'b0;
    end else if (st_reg == ST_OFF && cnt_reg == off_reg - 17'h00001) begin
      line_oe_reg <= 1'b1;
    end else if (st_reg == ST_LOW) begin
      line_oe_reg <= !release_now;
    end else begin
      line_oe_reg <= mask_now;
    end
  end

  // ==========================================================
  // Line sampling
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      found_reg <= 1'b0;
    end else if (take) begin
      found_reg <= 1'b0;
    end else if (st_reg == ST_HIGH) begin
      if (cmd_reg.op == OP_RESET) begin
        if (cnt_reg >= samp_reg - 17'h00001 && cnt_reg <= win_reg - 17'h00001
            && !line_oe_reg && !BUS_LINE_I) begin
          found_reg <= 1'b1;
        end
      end else if (cnt_reg == samp_reg - 17'h00001) begin
        found_reg <= BUS_LINE_I;
      end
    end
  end

  // ==========================================================
  // Strong pullup controller
  // tick-gated high test in read slots and presence recovery
  assign line_high_ok = (ph_reg == PH_PRES2 || cmd_reg.op == OP_READ) ?
                        (tick && BUS_LINE_I) : 1'b1;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sp_reg <= SP_IDLE;
      ph_reg <= PH_RECOV;
      sp_cnt_reg <= 17'h00000;
      sp_dur_reg <= 17'h00000;
      spu_n_reg <= 1'b1;
    end else if (take) begin
      sp_reg <= SP_IDLE;
      spu_n_reg <= 1'b1;
    end else begin
      case (sp_reg)
        SP_IDLE: begin
          if (release_now) begin
            // turn-on delay, slot wait state adds a cycle
            sp_reg <= SP_DELAY;
            sp_cnt_reg <= 17'h00000;
            sp_dur_reg <= (cmd_reg.op == OP_RESET) ? DLY1_CYC : DLY3_CYC - 17'h00001;
            ph_reg <= (cmd_reg.op == OP_RESET) ? PH_PRES1 : PH_RECOV;
          end
        end
        SP_DELAY: begin
          if (sp_cnt_reg == sp_dur_reg - 17'h00001) begin
            sp_cnt_reg <= 17'h00000;
            if (ph_reg == PH_PRES1) begin
              sp_reg <= SP_ON;
              sp_dur_reg <= sp_od ? ON1_OD : ON1_STD;
              spu_n_reg <= 1'b0;
            end else begin
              sp_reg <= SP_WAIT;
            end
          end else begin
            sp_cnt_reg <= sp_cnt_reg + 17'h00001;
          end
        end
        SP_WAIT: begin
          // enable at once in write slots, else on a tick with the line high
          if (line_high_ok) begin
            spu_n_reg <= 1'b0;
            sp_cnt_reg <= 17'h00000;
            sp_reg <= SP_ON;
            if (ph_reg == PH_PRES2) begin
              sp_dur_reg <= ON2_CYC;
            end else if (cmd_reg.last_bit && cont_reg) begin
              sp_reg <= SP_HOLD;
            end else if (cmd_reg.op == OP_WRITE && !cmd_reg.bit_val) begin
              sp_dur_reg <= sp_od ? ON4_OD : ON4_STD;
            end else begin
              sp_dur_reg <= sp_od ? ON3_OD : ON3_STD_CYC;
            end
          end
        end
        SP_ON: begin
          if (sp_cnt_reg == sp_dur_reg - 17'h00001) begin
            spu_n_reg <= 1'b1;
            sp_cnt_reg <= 17'h00000;
            if (ph_reg == PH_PRES1) begin
              sp_reg <= SP_DELAY;
              ph_reg <= PH_PRES2;
              sp_dur_reg <= sp_od ? DLY2_OD_CYC : DLY2_STD_CYC;
            end else begin
              sp_reg <= SP_IDLE;
            end
          end else begin
            sp_cnt_reg <= sp_cnt_reg + 17'h00001;
          end
        end
        SP_HOLD: begin
          spu_n_reg <= 1'b0;
        end
        default: begin
          sp_reg <= SP_IDLE;
          spu_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // State clock and result path
  state_clock_tick u_tick (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .fast_i(sp_od),
    .tick_o(tick)
  );

  always_comb begin
    rsp_in.op = cmd_reg.op;
    rsp_in.bit_val = (cmd_reg.op == OP_WRITE) ? cmd_reg.bit_val : found_reg;
  end

  result_skid_buffer u_buf (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .in_valid_i(st_reg == ST_POST),
    .in_ready_o(buf_ready),
    .in_data_i(rsp_in),
    .out_valid_o(RSP_VALID_O),
    .out_ready_i(RSP_READY_I),
    .out_data_o(RSP_O)
  );
endmodule

// ### sw_timing_props.sv
`timescale 1ns/100ps
module sw_timing_props
  import bus_timing_pkg::*;
#(
  parameter logic [16:0] RSTL_OD_CYC = 17'h1EC3
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_READY_O,
  input wire cmd_s CMD_I,
  input wire speed_e SPEED_I,
  input wire logic BUS_LINE_I,
  input wire logic BUS_LINE_O,
  input wire logic BUS_LINE_OE_O,
  input wire logic STRONG_PULLUP_ENABLE_N_O
);
  // ==========
  // Operation seen at take
  op_e op_reg;
  speed_e spd_reg;
  logic bit_reg;
  logic [16:0] low_cnt_reg;
  logic [9:0] off_cnt_reg;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      op_reg <= OP_RESET;
      spd_reg <= SPEED_STD;
      bit_reg <= 1'b0;
    end else if (CMD_VALID_I && CMD_READY_O) begin
      op_reg <= CMD_I.op;
      spd_reg <= SPEED_I;
      bit_reg <= CMD_I.bit_val;
    end
  end
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) low_cnt_reg <= 17'h0;
    else low_cnt_reg <= BUS_LINE_OE_O ? low_cnt_reg + 17'h1 : 17'h0;
  end
  // Cycles since the pullup was last dropped, saturating
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) off_cnt_reg <= 10'h0;
    else if (!STRONG_PULLUP_ENABLE_N_O) off_cnt_reg <= 10'h0;
    else if (off_cnt_reg != 10'h3FF) off_cnt_reg <= off_cnt_reg + 10'h1;
  end
  // ==========
  // Line and pullup relations
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_line_only_low: assert property (
    BUS_LINE_O == 1'b0) else $error("line data output not low");
  a_no_pullup_drive: assert property (
    BUS_LINE_OE_O |-> STRONG_PULLUP_ENABLE_N_O) else $error("pullup on while pulling low");
  a_take_pullup_off: assert property (
    CMD_VALID_I && CMD_READY_O |-> ##2 STRONG_PULLUP_ENABLE_N_O [*8])
    else $error("pullup not dropped after take");
  a_off_before_low: assert property (
    $rose(BUS_LINE_OE_O) |-> off_cnt_reg >= (op_reg == OP_RESET ? 10'h0C8 : 10'h064))
    else $error("pullup turn-off too short");
  a_reset_low_od: assert property (
    $fell(BUS_LINE_OE_O) && op_reg == OP_RESET && spd_reg == SPEED_OD
    |-> low_cnt_reg == RSTL_OD_CYC) else $error("reset low time wrong");
  a_write_low_od: assert property (
    $fell(BUS_LINE_OE_O) && op_reg == OP_WRITE && spd_reg == SPEED_OD
    |-> low_cnt_reg == (bit_reg ? 17'h7D : 17'h4E2)) else $error("write low time wrong");
  a_pullup_line_high: assert property (
    $fell(STRONG_PULLUP_ENABLE_N_O) |-> BUS_LINE_I) else $error("pullup on with line low");
  a_write_recovery_on: assert property (
    $fell(BUS_LINE_OE_O) && op_reg == OP_WRITE
    |-> ##[100:140] $fell(STRONG_PULLUP_ENABLE_N_O)) else $error("no pullup after write");
endmodule

bind single_wire_bus_master_timing sw_timing_props #(.RSTL_OD_CYC(RSTL_OD_CYC)) props_inst (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O),
  .CMD_I(CMD_I), .SPEED_I(SPEED_I), .BUS_LINE_I(BUS_LINE_I), .BUS_LINE_O(BUS_LINE_O),
  .BUS_LINE_OE_O(BUS_LINE_OE_O), .STRONG_PULLUP_ENABLE_N_O(STRONG_PULLUP_ENABLE_N_O)
);

// ### sw_slave_model.sv
`timescale 1ns/100ps
module sw_slave_model (
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic arm_i,
  input wire logic from_start_i,
  input wire logic [15:0] wait_i,
  input wire logic [15:0] width_i,
  input wire logic line_i,
  output logic pull_o,
  output logic seen_o
);
  // ==========
  // Answer pulse after a master edge
  logic drive_reg;
  logic trig;
  int cnt_reg;
  int stop;
  initial begin
    drive_reg = 1'b0;
    cnt_reg = -1;
    pull_o = 1'b0;
    seen_o = 1'b0;
  end
  assign stop = int'(wait_i) + int'(width_i);
  assign trig = arm_i && (from_start_i ? drive_i && !drive_reg : !drive_i && drive_reg);
  always @(posedge clk_i) begin
    drive_reg <= drive_i;
    if (trig) cnt_reg <= 0;
    else if (cnt_reg >= 0 && cnt_reg < stop) cnt_reg <= cnt_reg + 1;
    else cnt_reg <= -1;
    pull_o <= cnt_reg >= int'(wait_i) && cnt_reg < stop;
    if (cnt_reg == int'(wait_i)) seen_o <= line_i;
  end
endmodule

// ### single_wire_bus_master_timing_tb_top.sv
`timescale 1ns/100ps
module single_wire_bus_master_timing_tb_top
  import bus_timing_pkg::*;
();
  logic clk, rst, cmd_valid, cmd_ready, cont, pulse_masking_mode, line, oe, line_o, pu_n;
  logic rsp_valid, rsp_ready, arm, from_start, slave_pull, seen;
  logic [15:0] s_wait, s_width;
  cmd_s cmd;
  speed_e speed;
  rsp_s rsp;
  int err_count = 0, checks_done = 0, cyc = 0, t_take = 0, t_valid = 0;
  int t_rel = 0, t_pu = 0, oe_len = 0, pu_len = 0, oe_run = 0, pu_run = 0;
  speed_e ws[4] = '{SPEED_OD, SPEED_OD, SPEED_STD, SPEED_LONG};
  logic wb[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int wl[4] = '{125, 1250, 750, 1125};
  int wt[4] = '{2377, 2002, 10877, 10877};
  int wo[4] = '{1125, 125, 8000, 8000};

  // Open-drain line with pull-up
  assign line = !(oe || slave_pull);

  // Short standard reset keeps the masking run brief
  single_wire_bus_master_timing #(
    .RSTL_STD_CYC(17'h00190),
    .RSTH_STD_CYC(17'h00FA0)
  ) single_wire_bus_master_timing_inst (
    .CLK_I(clk), .RESET_I(rst), .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready),
    .CMD_I(cmd), .SPEED_I(speed), .PULSE_MASKING_MODE_I(pulse_masking_mode), .SPU_CONTINUOUS_I(cont),
    .BUS_LINE_I(line), .BUS_LINE_O(line_o), .BUS_LINE_OE_O(oe),
    .STRONG_PULLUP_ENABLE_N_O(pu_n), .RSP_VALID_O(rsp_valid), .RSP_READY_I(rsp_ready),
    .RSP_O(rsp)
  );
  sw_slave_model sw_slave_model_inst (
    .clk_i(clk), .drive_i(oe), .arm_i(arm), .from_start_i(from_start),
    .wait_i(s_wait), .width_i(s_width), .line_i(line), .pull_o(slave_pull), .seen_o(seen)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========
  // Event timestamps in cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd_valid && cmd_ready) t_take <= cyc;
    if (rsp_valid && t_valid <= t_take) t_valid <= cyc;
    if (oe) oe_run <= oe_run + 1;
    else if (oe_run > 0) begin
      oe_len <= oe_run;
      oe_run <= 0;
      t_rel <= cyc;
    end
    if (!pu_n && pu_run == 0) t_pu <= cyc;
    if (!pu_n) pu_run <= pu_run + 1;
    else if (pu_run > 0) begin
      pu_len <= pu_run;
      pu_run <= 0;
    end
  end

  // ==========
  // Access and compare tasks
  task automatic chk_num(string name, int lo, int hi, int got);
    checks_done++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic chk_bit(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_rsp(rsp_s exp);
    checks_done++;
    if (rsp !== exp) begin
      err_count++;
      $display("[ERR] result expected %h seen %h", exp, rsp);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(op_e o, logic b, logic f, logic l, speed_e s);
    int n;
    n = 0;
    while (!cmd_ready && n < 40000) begin
      cycles(1);
      n++;
    end
    if (n >= 40000) chk_bit("cmd_ready", 1'b1, cmd_ready);
    cmd_valid = 1'b1;
    cmd = '{o, b, f, l};
    speed = s;
    cycles(1);
    cmd_valid = 1'b0;
  endtask
  task automatic expect_rsp(op_e o, logic b);
    int n;
    n = 0;
    while (!rsp_valid && n < 40000) begin
      cycles(1);
      n++;
    end
    if (n >= 40000) chk_bit("rsp_valid", 1'b1, rsp_valid);
    chk_rsp(rsp_s'{o, b});
    rsp_ready = 1'b1;
    cycles(1);
    rsp_ready = 1'b0;
    cycles(1);
  endtask
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========
  // Test sequence
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    speed = SPEED_OD;
    pulse_masking_mode = 1'b0;
    cont = 1'b0;
    rsp_ready = 1'b0;
    arm = 1'b1;
    from_start = 1'b0;
    s_wait = 16'h0177;
    s_width = 16'h04E2;
    cycles(2);
    rst = 1'b0;
    send(OP_RESET, 1'b0, 1'b0, 1'b0, SPEED_OD);
    expect_rsp(OP_RESET, 1'b1);
    chk_num("reset low", 7875, 7875, oe_len);
    chk_num("reset total", 17377, 17378, t_valid - t_take);
    chk_num("monitor delay", 5120, 5140, t_pu - t_rel);
    chk_num("recovery on", 1250, 1250, pu_len);
    arm = 1'b0;
    send(OP_RESET, 1'b0, 1'b0, 1'b0, SPEED_OD);
    expect_rsp(OP_RESET, 1'b0);
    arm = 1'b1;
    from_start = 1'b1;
    s_width = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      s_wait = (ws[i] == SPEED_OD) ? 16'h00FA : ((ws[i] == SPEED_LONG) ? 16'h0C35 : 16'h0753);
      send(OP_WRITE, wb[i], logic'(i == 0), 1'b0, ws[i]);
      expect_rsp(OP_WRITE, wb[i]);
      chk_bit("slave sample", wb[i], seen);
      chk_num("write low", wl[i], wl[i], oe_len);
      chk_num("slot total", wt[i], wt[i] + 1, t_valid - t_take);
      chk_num("write on", wo[i], wo[i], pu_len);
    end
    arm = 1'b1;
    from_start = 1'b1;
    s_wait = 16'h0000;
    s_width = 16'h01F4;
    send(OP_READ, 1'b0, 1'b0, 1'b0, SPEED_OD);
    expect_rsp(OP_READ, 1'b0);
    chk_num("read pullup wait", 370, 395, t_pu - t_rel);
    arm = 1'b0;
    cont = 1'b1;
    send(OP_WRITE, 1'b0, 1'b0, 1'b1, SPEED_OD);
    expect_rsp(OP_WRITE, 1'b0);
    cycles(2000);
    chk_bit("held pullup", 1'b0, pu_n);
    send(OP_READ, 1'b0, 1'b0, 1'b0, SPEED_OD);
    cycles(3);
    chk_bit("pullup dropped", 1'b1, pu_n);
    expect_rsp(OP_READ, 1'b1);
    cont = 1'b0;
    for (int i = 0; i < 3; i++) send(OP_WRITE, logic'(i != 1), 1'b0, 1'b0, SPEED_OD);
    cycles(4000);
    chk_bit("stalled ready", 1'b0, cmd_ready);
    for (int i = 0; i < 3; i++) expect_rsp(OP_WRITE, logic'(i != 1));
    pulse_masking_mode = 1'b1;
    send(OP_RESET, 1'b0, 1'b0, 1'b0, SPEED_STD);
    expect_rsp(OP_RESET, 1'b0);
    chk_num("mask drive", 2125, 2125, oe_len);
    close_out();
  end

  initial begin
    #760000;
    err_count++;
    close_out();
  end
endmodule
